// >>> hdl/sample_fifo_dev.sv
// Purpose: 32-entry pulse sample FIFO with rollover, threshold and byte readout
// Assumes: Samples arrive as one-cycle strobes from logic on sys_clk
// Notes:   Status register at 0x3E holds the almost-full level and byte phase
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_dev (
    input  wire logic                              sys_clk,
    input  wire logic                              reset_n,
    input  wire logic                              sample_valid,
    input  wire logic [sample_fifo_pkg::SAMPLE_W-1:0] sample_data,
    output logic                                   sample_dropped,
    sample_fifo_if.dev                             bus
);
    import sample_fifo_pkg::*;

    logic [SAMPLE_W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0]    wr_idx_q;
    logic [PTR_W-1:0]    rd_idx_q;
    logic [PTR_W:0]      fill_q;
    logic [OVF_W-1:0]    ovf_q;
    logic [7:0]          cfg_q;
    logic [1:0]          phase_q;
    logic [7:0]          rdata_q;
    logic                afull_q;
    logic                drop_q;
    logic [7:0]          out_byte;
    logic                rollover;
    logic                full;
    logic                store;
    logic                overwrite;
    logic                byte_done;
    logic                sample_done;
    logic [PTR_W:0]      empty_cnt;

    // Pointers are five bits wide, so the increment wraps 31 to 0 by itself
    function automatic logic [PTR_W-1:0] next_idx(input logic [PTR_W-1:0] p);
        next_idx = p + PTR_ONE;
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = bus.wr && (bus.addr == a);
    endfunction

    function automatic logic rd_hit(input logic [7:0] a);
        rd_hit = bus.rd && (bus.addr == a);
    endfunction

    // One decoder for every readable offset; unmapped offsets read as zero
    function automatic logic [7:0] reg_view(input logic [7:0] a);
        case (a)
            ADDR_CFG:       reg_view = cfg_q;
            ADDR_WR_INDEX:  reg_view = {3'h0, wr_idx_q};
            ADDR_RD_INDEX:  reg_view = {3'h0, rd_idx_q};
            ADDR_OVF_COUNT: reg_view = {4'h0, ovf_q};
            ADDR_READOUT:   reg_view = out_byte;
            ADDR_IDENT:     reg_view = IDENT_VALUE;
            ADDR_STATUS:    reg_view = {5'h0, phase_q, afull_q};
            default:        reg_view = '0;
        endcase
    endfunction

    assign rollover    = cfg_q[CFG_ROLL_BIT];
    assign full        = (fill_q == FULL_CNT);
    assign store       = sample_valid && (rollover || !full);
    // In rollover mode a read finishing in the same cycle frees the slot, so nothing is lost
    assign overwrite   = sample_valid && rollover && full && !sample_done;
    assign byte_done   = rd_hit(ADDR_READOUT);
    assign sample_done = byte_done && (phase_q == BYTE_LAST);
    assign empty_cnt   = FULL_CNT - fill_q;

    // Samples are stored whole; readout splits them afterwards
    sample_byte_split u_split (
        .sample    (mem_q[rd_idx_q]),
        .phase     (phase_q),
        .data_byte (out_byte)
    );

    // Storage has no reset; only the indices say what is valid
    always_ff @(posedge sys_clk) begin
        if (store) begin
            mem_q[wr_idx_q] <= sample_data;
        end
    end

    // Upper config bits are reserved and read back as zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= CFG_RESET;
        end else if (wr_hit(ADDR_CFG)) begin
            cfg_q <= {3'h0, bus.wdata[4:0]};
        end
    end

    // A host write wins over a store in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_idx_q <= '0;
        end else if (wr_hit(ADDR_WR_INDEX)) begin
            wr_idx_q <= bus.wdata[PTR_W-1:0];
        end else if (store) begin
            wr_idx_q <= next_idx(wr_idx_q);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_idx_q <= '0;
        end else if (wr_hit(ADDR_RD_INDEX)) begin
            rd_idx_q <= bus.wdata[PTR_W-1:0];
        end else if (sample_done) begin
            rd_idx_q <= next_idx(rd_idx_q);
        end
    end

    // Host write to the read index restarts the byte phase for a clean re-read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= '0;
        end else if (wr_hit(ADDR_RD_INDEX) || sample_done) begin
            phase_q <= '0;
        end else if (byte_done) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // Fill level is what is unread; pointer writes clear it to zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fill_q <= '0;
        end else if (wr_hit(ADDR_WR_INDEX) || wr_hit(ADDR_RD_INDEX)) begin
            fill_q <= '0;
        end else if (store && !overwrite && !(sample_done && fill_q != '0)) begin
            fill_q <= fill_q + 6'h01;
        end else if (!store && sample_done && fill_q != '0) begin
            fill_q <= fill_q - 6'h01;
        end
    end

    // The count holds at its ceiling until the host clears it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf_q <= '0;
        end else if (wr_hit(ADDR_OVF_COUNT)) begin
            ovf_q <= bus.wdata[OVF_W-1:0];
        end else if (overwrite && ovf_q != OVF_MAX) begin
            ovf_q <= ovf_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            afull_q <= 1'b0;
        end else begin
            afull_q <= (empty_cnt == {2'h0, cfg_q[THR_W-1:0]});
        end
    end

    // Drop pulse lets the sample side count samples refused when full in discard mode; rollover overwrites do not pulse it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drop_q <= 1'b0;
        end else begin
            drop_q <= sample_valid && !store;
        end
    end

    // Address is never advanced here; the readout offset stays put
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (bus.rd) begin
            rdata_q <= reg_view(bus.addr);
        end else begin
            rdata_q <= '0;
        end
    end

    assign bus.rdata       = rdata_q;
    assign bus.almost_full = afull_q;
    assign sample_dropped  = drop_q;
endmodule // sample_fifo_dev
`default_nettype wire

// >>> shared/sample_fifo_pkg.sv
// Purpose: Shared constants for the pulse sample FIFO and its host-side reader
// Assumes: 8-bit register access through the sample_fifo_if carrier
// Notes:   Offsets follow the register map; config and control offsets are local
`default_nettype none
package sample_fifo_pkg;
    localparam int unsigned DEPTH          = 32;
    localparam int unsigned PTR_W          = 5;
    localparam int unsigned SAMPLE_W       = 18;
    localparam int unsigned THR_W          = 4;
    localparam int unsigned OVF_W          = 4;
    localparam logic [7:0]  ADDR_CFG       = 8'h37;
    localparam logic [7:0]  ADDR_WR_INDEX  = 8'h38;
    localparam logic [7:0]  ADDR_RD_INDEX  = 8'h39;
    localparam logic [7:0]  ADDR_OVF_COUNT = 8'h3A;
    localparam logic [7:0]  ADDR_READOUT   = 8'h3B;
    localparam logic [7:0]  ADDR_IDENT     = 8'h3D;
    localparam logic [7:0]  ADDR_STATUS    = 8'h3E;
    localparam logic [7:0]  HOST_ADDR_CTRL = 8'h00;
    localparam logic [7:0]  HOST_ADDR_STAT = 8'h01;
    localparam logic [7:0]  HOST_ADDR_DLO  = 8'h02;
    localparam logic [7:0]  HOST_ADDR_DMID = 8'h03;
    localparam logic [7:0]  HOST_ADDR_DHI  = 8'h04;
    localparam logic [7:0]  HOST_ADDR_RAW  = 8'h05;
    localparam int unsigned CFG_ROLL_BIT   = 4;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [7:0]  IDENT_VALUE    = 8'h5A; // Arbitrary value
    localparam logic [1:0]  BYTE_LAST      = 2'h2;
    localparam logic [OVF_W-1:0] OVF_MAX   = 4'hF;
    localparam logic [PTR_W-1:0] PTR_ONE   = 5'h01;
    localparam logic [PTR_W:0]   FULL_CNT  = 6'h20;
endpackage
`default_nettype wire

// >>> shared/sample_fifo_if.sv
// Purpose: Register link between the sample FIFO device and its host reader
// Assumes: One clock; host issues strobes, device answers one cycle later
// Notes:   Stands in for the serial register link as a parallel byte port
`timescale 1ns/1ps
`default_nettype none
interface sample_fifo_if (input wire logic sys_clk);
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       almost_full;
    modport dev (input addr, input wdata, input wr, input rd,
                 output rdata, output almost_full);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata, input almost_full);
endinterface
`default_nettype wire

// >>> hdl/sample_byte_split.sv
// Purpose: Picks one byte of an 18-bit sample by byte phase
// Assumes: Phase 0..2, low byte first
// Notes:   Pure combinational lane selector
`timescale 1ns/1ps
`default_nettype none
module sample_byte_split (
    input  wire logic [sample_fifo_pkg::SAMPLE_W-1:0] sample,
    input  wire logic [1:0]                           phase,
    output logic      [7:0]                           data_byte
);
    import sample_fifo_pkg::*;
    always_comb begin
        case (phase)
            2'h0:    data_byte = sample[7:0];
            2'h1:    data_byte = sample[15:8];
            default: data_byte = {6'h00, sample[17:16]};
        endcase
    end
endmodule // sample_byte_split
`default_nettype wire

// >>> hdl/sample_fifo_host.sv
// Purpose: Host-side reader that clears indices, enables and drains samples
// Assumes: Software drives a plain register port on sys_clk
// Notes:   One fetch reads three readout bytes back to back
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_host (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata,
    sample_fifo_if.host      bus
);
    import sample_fifo_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CLEAR = 5'b00010,
        ST_CFG   = 5'b00100,
        ST_FETCH = 5'b01000,
        ST_WAIT  = 5'b10000
    } host_state_t;

    host_state_t     state_q;
    logic [1:0]      step_q;
    logic [7:0]      addr_q;
    logic [7:0]      wdata_q;
    logic            wr_q;
    logic            rd_q;
    logic [7:0]      sw_rdata_q;
    logic [7:0]      cfg_shadow_q;
    logic [SAMPLE_W-1:0] sample_q;
    logic            busy_q;
    logic            rd_pending_q;
    logic [1:0]      byte_cnt_q;
    logic            raw_rd_q;
    logic [7:0]      raw_q;

    // Control: bit0 start (clear then config), bit1 fetch one sample
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= ST_IDLE;
            step_q       <= '0;
            addr_q       <= '0;
            wdata_q      <= '0;
            wr_q         <= 1'b0;
            rd_q         <= 1'b0;
            busy_q       <= 1'b0;
            cfg_shadow_q <= CFG_RESET;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    busy_q <= 1'b0;
                    if (sw_wr && sw_addr == HOST_ADDR_CTRL && sw_wdata[0]) begin
                        cfg_shadow_q <= {3'h0, sw_wdata[7:3]};
                        state_q      <= ST_CLEAR;
                        step_q       <= '0;
                        busy_q       <= 1'b1;
                    end else if (sw_wr && sw_addr == HOST_ADDR_CTRL && sw_wdata[1]) begin
                        state_q <= ST_FETCH;
                        step_q  <= '0;
                        busy_q  <= 1'b1;
                    end else if (sw_rd && sw_addr == HOST_ADDR_RAW) begin
                        addr_q <= sw_wdata;
                        rd_q   <= 1'b1;
                    end
                end
                ST_CLEAR: begin
                    wr_q    <= 1'b1;
                    wdata_q <= '0;
                    case (step_q)
                        2'h0:    addr_q <= ADDR_WR_INDEX;
                        2'h1:    addr_q <= ADDR_RD_INDEX;
                        default: addr_q <= ADDR_OVF_COUNT;
                    endcase
                    step_q <= step_q + 2'h1;
                    if (step_q == BYTE_LAST) begin
                        state_q <= ST_CFG;
                    end
                end
                ST_CFG: begin
                    wr_q    <= 1'b1;
                    addr_q  <= ADDR_CFG;
                    wdata_q <= cfg_shadow_q;
                    state_q <= ST_IDLE;
                end
                ST_FETCH: begin
                    rd_q   <= 1'b1;
                    addr_q <= ADDR_READOUT;
                    step_q <= step_q + 2'h1;
                    if (step_q == BYTE_LAST) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Bytes land one cycle after each strobe; assemble low first
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pending_q <= 1'b0;
            byte_cnt_q   <= '0;
            sample_q     <= '0;
            raw_rd_q     <= 1'b0;
            raw_q        <= '0;
        end else begin
            rd_pending_q <= rd_q && (addr_q == ADDR_READOUT) && state_q != ST_IDLE;
            raw_rd_q     <= rd_q && state_q == ST_IDLE;
            if (raw_rd_q) begin
                raw_q <= bus.rdata;
            end
            if (rd_pending_q) begin
                case (byte_cnt_q)
                    2'h0:    sample_q[7:0]   <= bus.rdata;
                    2'h1:    sample_q[15:8]  <= bus.rdata;
                    default: sample_q[17:16] <= bus.rdata[1:0];
                endcase
                byte_cnt_q <= (byte_cnt_q == BYTE_LAST) ? 2'h0 : byte_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_rdata_q <= '0;
        end else if (sw_rd) begin
            case (sw_addr)
                HOST_ADDR_STAT: sw_rdata_q <= {6'h0, bus.almost_full, busy_q};
                HOST_ADDR_DLO:  sw_rdata_q <= sample_q[7:0];
                HOST_ADDR_DMID: sw_rdata_q <= sample_q[15:8];
                HOST_ADDR_DHI:  sw_rdata_q <= {6'h0, sample_q[17:16]};
                HOST_ADDR_RAW:  sw_rdata_q <= raw_q;
                default:        sw_rdata_q <= '0;
            endcase
        end else begin
            sw_rdata_q <= '0;
        end
    end

    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;
    assign sw_rdata  = sw_rdata_q;
endmodule // sample_fifo_host
`default_nettype wire

// >>> dv/sample_fifo_sva.sv
// Purpose: Bus-side checks on the link between the FIFO device and its reader
// Assumes: Strobes one cycle wide, read data only in the cycle after rd
// Notes:   Helper logic tracks the byte phase and the read index
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_sva (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       almost_full
);
    import sample_fifo_pkg::*;
    logic [1:0]       phase_q;
    logic [PTR_W-1:0] rd_idx_q;
    logic             take_rd;
    assign take_rd = rd && (addr == ADDR_READOUT);
    // A read index write restarts the phase, so a re-read starts from byte 0
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 2'h0;
        end else if (wr && addr == ADDR_RD_INDEX) begin
            phase_q <= 2'h0;
        end else if (take_rd) begin
            phase_q <= (phase_q == BYTE_LAST) ? 2'h0 : phase_q + 2'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_idx_q <= '0;
        end else if (wr && addr == ADDR_RD_INDEX) begin
            rd_idx_q <= wdata[PTR_W-1:0];
        end else if (take_rd && phase_q == BYTE_LAST) begin
            rd_idx_q <= rd_idx_q + PTR_ONE;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_rd_index_track: assert property (
        rd && addr == ADDR_RD_INDEX |=> rdata == {3'h0, $past(rd_idx_q)})
        else $error("read index differs from tracked value");
    a_wr_index_width: assert property (
        rd && addr == ADDR_WR_INDEX |=> rdata[7:5] == 3'h0)
        else $error("write index has bits above four");
    a_ovf_width: assert property (
        rd && addr == ADDR_OVF_COUNT |=> rdata[7:4] == 4'h0)
        else $error("overflow count wider than four bits");
    a_status_level: assert property (
        rd && addr == ADDR_STATUS |=> rdata == {5'h00, $past(phase_q), $past(almost_full)})
        else $error("status does not match level and phase");
    a_top_byte_pad: assert property (
        take_rd && phase_q == BYTE_LAST |=> rdata[7:2] == 6'h00)
        else $error("third byte carries bits above two");
    a_ident_value: assert property (rd && addr == ADDR_IDENT |=> rdata == IDENT_VALUE)
        else $error("identifier value wrong");
    a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without a read");
    a_strobe_apart: assert property (!(wr && rd))
        else $error("write and read strobes together");
    c_third_byte: cover property (take_rd && phase_q == BYTE_LAST);
    c_almost_full: cover property ($rose(almost_full));
    c_rd_index_wr: cover property (wr && addr == ADDR_RD_INDEX);
endmodule // sample_fifo_sva
`default_nettype wire

// >>> dv/tb.sv
// Purpose: Drives the host reader and the sample side, checks both ends meet
// Assumes: Host busy flag covers every init and fetch; raw register reads never set it
// Notes:   Raw reads are issued twice; the second returns the first's result
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sample_fifo_pkg::*;
    typedef struct packed { logic [7:0] a; logic [7:0] e; } row_t;
    logic                sys_clk;
    logic                reset_n;
    logic                sample_valid;
    logic [SAMPLE_W-1:0] sample_data;
    logic                sample_dropped;
    logic [7:0]          sw_addr;
    logic [7:0]          sw_wdata;
    logic                sw_wr;
    logic                sw_rd;
    logic [7:0]          sw_rdata;
    logic [7:0]          v8;
    logic [SAMPLE_W-1:0] v18;
    int                  fails;
    int                  compares;
    int                  drops;
    int                  cycles;
    row_t rows [7] = '{'{ADDR_CFG, 8'h00}, '{ADDR_WR_INDEX, 8'h00}, '{ADDR_RD_INDEX, 8'h00},
        '{ADDR_OVF_COUNT, 8'h00}, '{ADDR_IDENT, IDENT_VALUE}, '{ADDR_STATUS, 8'h00},
        '{8'h40, 8'h00}};
    sample_fifo_if bif (.sys_clk(sys_clk));
    sample_fifo_dev i_sample_fifo_dev (.sys_clk(sys_clk), .reset_n(reset_n),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_dropped(sample_dropped), .bus(bif));
    sample_fifo_host i_sample_fifo_host (.sys_clk(sys_clk), .reset_n(reset_n),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .bus(bif));
    sample_fifo_sva i_sample_fifo_sva (.sys_clk(sys_clk), .reset_n(reset_n),
        .addr(bif.addr), .wdata(bif.wdata), .wr(bif.wr), .rd(bif.rd),
        .rdata(bif.rdata), .almost_full(bif.almost_full));
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    function automatic logic [SAMPLE_W-1:0] smp(input int k);
        return SAMPLE_W'(k * 32'h00011D4B + 32'h0002A5C3);
    endfunction
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check({10'h000, got}, {10'h000, exp});
    endtask
    task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic sw_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_rd    <= 1'b1;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        @(negedge sys_clk);
        q = sw_rdata;
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int n = 0; n < 40 && s[0] !== 1'b0; n++) begin
            sw_read(HOST_ADDR_STAT, 8'h00, s);
        end
        chk8({7'h00, s[0]}, 8'h00);
    endtask
    task automatic raw(input logic [7:0] a, output logic [7:0] q);
        sw_read(HOST_ADDR_RAW, a, q);
        wait_idle();
        sw_read(HOST_ADDR_RAW, a, q);
        wait_idle();
    endtask
    task automatic init(input logic [4:0] cfg);
        sw_write(HOST_ADDR_CTRL, {cfg, 3'b001});
        wait_idle();
    endtask
    task automatic fetch(output logic [SAMPLE_W-1:0] q);
        logic [7:0] b0, b1, b2;
        sw_write(HOST_ADDR_CTRL, 8'h02);
        wait_idle();
        sw_read(HOST_ADDR_DLO, 8'h00, b0);
        sw_read(HOST_ADDR_DMID, 8'h00, b1);
        sw_read(HOST_ADDR_DHI, 8'h00, b2);
        chk8(b2 & 8'hFC, 8'h00);
        q = {b2[1:0], b1, b0};
    endtask
    task automatic push(input int first, input int n);
        for (int k = first; k < first + n; k++) begin
            @(posedge sys_clk);
            sample_valid <= 1'b1;
            sample_data  <= smp(k);
            @(posedge sys_clk);
            sample_valid <= 1'b0;
        end
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic status(input logic [7:0] exp);
        sw_read(HOST_ADDR_STAT, 8'h00, v8);
        chk8(v8, exp);
    endtask
    always @(posedge sys_clk) begin
        if (sample_dropped === 1'b1) drops++;
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        {sample_valid, sw_wr, sw_rd} = 3'h0;
        sample_data = '0;
        sw_addr = 8'h00;
        sw_wdata = 8'h00;
        {fails, compares, drops, cycles} = '0;
        reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            raw(rows[i].a, v8);
            chk8(v8, rows[i].e);
        end
        status(8'h00);
        // Discard mode, threshold 0: the level rises only when truly full
        init(5'h00);
        push(0, 31);
        status(8'h00);
        push(31, 1);
        status(8'h02);
        push(32, 1);
        chk8(8'(drops), 8'h01);
        raw(ADDR_WR_INDEX, v8);
        chk8(v8, 8'h00);
        fetch(v18);
        check(v18, smp(0));
        raw(ADDR_RD_INDEX, v8);
        chk8(v8, 8'h01);
        push(33, 1);
        raw(ADDR_WR_INDEX, v8);
        chk8(v8, 8'h01);
        fetch(v18);
        check(v18, smp(1));
        // Rollover with threshold 2, then 17 overwrites to saturate the count
        init(5'h12);
        push(100, 29);
        status(8'h00);
        push(129, 1);
        status(8'h02);
        push(130, 19);
        raw(ADDR_OVF_COUNT, v8);
        chk8(v8, 8'h0F);
        raw(ADDR_RD_INDEX, v8);
        chk8(v8, 8'h00);
        raw(ADDR_WR_INDEX, v8);
        chk8(v8, 8'h11);
        fetch(v18);
        check(v18, smp(132));
        chk8(8'(drops), 8'h01);
        // Mid-run reset brings config, count and level back to defaults
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        raw(ADDR_CFG, v8);
        chk8(v8, CFG_RESET);
        raw(ADDR_OVF_COUNT, v8);
        chk8(v8, 8'h00);
        status(8'h00);
        summarize();
    end
endmodule // tb
`default_nettype wire
